// [hdl/packet_protocol_config_regs.sv]
// Packet protocol configuration registers of the transceiver,
// reached over the serial port, and the small logic they steer.
// Assumes packet engine signals are on the same clock; only the
// serial pins are asynchronous.
`timescale 1ns/1ns
`include "pktcfg_params.svh"
module packet_protocol_config_regs (
  input  wire logic                   clock,
  input  wire logic                   rstn,
  // Serial register pins
  input  wire logic                   spi_sclk,
  input  wire logic                   spi_csn,
  input  wire logic                   spi_mosi,
  output logic                        spi_miso,
  output logic                        spi_miso_oe,
  // Bits held in neighbouring registers
  input  wire logic                   auto_filter_en,
  input  wire logic                   dual_sync_en,
  input  wire logic                   wake_reload_on_sync,
  input  wire logic                   seed_reload_en,
  input  wire logic                   cs_timeout_mask,
  input  wire logic                   sync_quality_timeout_mask,
  input  wire logic                   preamble_quality_timeout_mask,
  // Receive quality terms
  input  wire logic                   carrier_sense,
  input  wire logic                   sync_quality,
  input  wire logic                   preamble_quality,
  // FIFO fill levels, 0 to 128
  input  wire logic [7:0]             rx_fill,
  input  wire logic [7:0]             tx_fill,
  // Received packet header strobe
  input  wire logic                   rx_pkt_valid,
  input  wire pktcfg_pkg::rx_packet_s rx_pkt,
  // Engine events
  input  wire logic                   sync_detect,
  input  wire logic                   backoff_start,
  // Results
  output pktcfg_pkg::fifo_flags_s     fifo_flags,
  output pktcfg_pkg::tx_header_s      tx_header,
  output logic                        persistent_receive,
  output logic                        rx_timeout_stop,
  output logic                        rx_accept,
  output logic                        rx_discard,
  output logic                        ack_send,
  output logic [31:0]                 alt_sync_word,
  output pktcfg_pkg::timer_period_s   rx_timeout_period,
  output pktcfg_pkg::timer_period_s   wake_period,
  output logic                        wake_load,
  output pktcfg_pkg::timer_period_s   wake_load_value,
  output logic [14:0]                 backoff_seed,
  output logic                        backoff_seed_load
);

  // ----------------------------------------
  // Register table
  // ----------------------------------------
  // Slice starts at the ack control register
  localparam logic [7:0] BASE = `ACK_AND_RECEIVE_CONTROL_OFS;

  // Reset value per register, in offset order
  localparam logic [7:0] RST_TABLE [0:`REG_COUNT-1] = '{
    `ACK_CTRL_RST,
    `FIFO_LEVEL_RST,
    `FIFO_LEVEL_RST,
    `FIFO_LEVEL_RST,
    `FIFO_LEVEL_RST,
    `FILTER_OPT_RST,
    `ZERO_RST,
    `ZERO_RST,
    `ZERO_RST,
    `ZERO_RST,
    `ZERO_RST,
    `ONE_RST,
    `ZERO_RST,
    `ONE_RST,
    `ZERO_RST,
    `ONE_RST,
    `ZERO_RST,
    `SEED_HIGH_RST,
    `ZERO_RST
  };

  // Writable bits per register; the rest are reserved
  localparam logic [7:0] MASK_TABLE [0:`REG_COUNT-1] = '{
    `ACK_CTRL_MASK,
    `SEVEN_BIT_MASK,
    `SEVEN_BIT_MASK,
    `SEVEN_BIT_MASK,
    `SEVEN_BIT_MASK,
    `FILTER_OPT_MASK,
    `FULL_MASK,
    `FULL_MASK,
    `FULL_MASK,
    `FULL_MASK,
    `FULL_MASK,
    `FULL_MASK,
    `FULL_MASK,
    `FULL_MASK,
    `FULL_MASK,
    `FULL_MASK,
    `FULL_MASK,
    `SEVEN_BIT_MASK,
    `FULL_MASK
  };

  logic [7:0] cfg_reg [0:`REG_COUNT-1];
  logic [7:0] bus_addr;
  logic [7:0] bus_wdata;
  logic [7:0] rd_data;
  logic       bus_wr;
  logic [7:0] index;
  logic       in_range;

  // ----------------------------------------
  // Serial access
  // ----------------------------------------
  spi_reg_port port_inst (
    .clock   (clock),
    .rstn    (rstn),
    .sclk    (spi_sclk),
    .csn     (spi_csn),
    .mosi    (spi_mosi),
    .rd_data (rd_data),
    .addr    (bus_addr),
    .wr_data (bus_wdata),
    .wr_en   (bus_wr),
    .miso    (spi_miso),
    .miso_oe (spi_miso_oe)
  );

  // Index into the slice; addresses outside it read as zero
  assign index    = bus_addr - BASE;
  assign in_range = (bus_addr >= BASE) && (bus_addr <= `BACKOFF_SEED_LOW_OFS);
  assign rd_data  = in_range ? cfg_reg[index[4:0]] : 8'h00;

  // One storage register per offset; reserved bits stay zero
  genvar i;
  generate
    for (i = 0; i < `REG_COUNT; i++) begin : g_reg
      always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
          cfg_reg[i] <= RST_TABLE[i];
        end else if (bus_wr && in_range && index == 8'(i)) begin
          cfg_reg[i] <= bus_wdata & MASK_TABLE[i];
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // Field decode
  // ----------------------------------------
  logic [7:0] ack_ctrl;
  logic [7:0] options;
  logic [7:0] src_mask, own_node, allcall, group, sender_id;
  logic [6:0] rx_full_level;
  logic [6:0] rx_empty_level;
  logic [6:0] tx_full_level;
  logic [6:0] tx_empty_level;
  logic       suppress_ack_request;
  logic       auto_ack;
  logic       timeout_combine_sel;

  // Whole bytes and threshold fields by slot
  assign ack_ctrl       = cfg_reg[0];
  assign rx_full_level  = cfg_reg[1][6:0];
  assign rx_empty_level = cfg_reg[2][6:0];
  assign tx_full_level  = cfg_reg[3][6:0];
  assign tx_empty_level = cfg_reg[4][6:0];
  assign options        = cfg_reg[5];
  assign src_mask       = cfg_reg[6];
  assign own_node       = cfg_reg[7];
  assign allcall        = cfg_reg[8];
  assign group          = cfg_reg[9];
  assign sender_id      = cfg_reg[10];

  // Single control bits
  assign suppress_ack_request = ack_ctrl[`SUPPRESS_ACK_BIT];
  assign auto_ack             = ack_ctrl[`AUTO_ACK_BIT];
  assign timeout_combine_sel  = options[`TIMEOUT_SEL_BIT];

  // ----------------------------------------
  // Receive filtering
  // ----------------------------------------
  logic filter_pass;

  // Decision is combinational; the verdict is registered below
  packet_filter filter_inst (
    .auto_filter_en (auto_filter_en),
    .dual_sync_en   (dual_sync_en),
    .options        (options),
    .src_mask       (src_mask),
    .own_node       (own_node),
    .allcall        (allcall),
    .group          (group),
    .sender_id      (sender_id),
    .pkt            (rx_pkt),
    .accept         (filter_pass)
  );

  // Verdict pulses one cycle after the header strobe
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rx_accept  <= 1'b0;
      rx_discard <= 1'b0;
    end else begin
      rx_accept  <= rx_pkt_valid & filter_pass;
      rx_discard <= rx_pkt_valid & ~filter_pass;
    end
  end

  // Ack only for packets that survive filtering
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ack_send <= 1'b0;
    end else begin
      ack_send <= rx_pkt_valid & filter_pass & rx_pkt.ack_req & auto_ack;
    end
  end

  // ----------------------------------------
  // Transmit header and receive mode
  // ----------------------------------------
  // Registered so the packet engine sees no decode glitches
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      tx_header          <= '0;
      persistent_receive <= 1'b0;
    end else begin
      tx_header.no_ack   <= suppress_ack_request;
      tx_header.dest     <= own_node;
      tx_header.src      <= sender_id;
      persistent_receive <= ack_ctrl[`PERSIST_RX_BIT];
    end
  end

  // ----------------------------------------
  // FIFO level flags
  // ----------------------------------------
  // Fill levels can reach 128, so compare at eight bits
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      fifo_flags <= '0;
    end else begin
      fifo_flags.rx_full  <= rx_fill >= {1'b0, rx_full_level};
      fifo_flags.rx_empty <= rx_fill <= {1'b0, rx_empty_level};
      fifo_flags.tx_full  <= tx_fill >= {1'b0, tx_full_level};
      fifo_flags.tx_empty <= tx_fill <= {1'b0, tx_empty_level};
    end
  end

  // ----------------------------------------
  // Receive timeout stop
  // ----------------------------------------
  logic [2:0] term_val;
  logic [2:0] term_en;
  logic       any_en;
  logic       or_hit;
  logic       and_hit;

  assign term_val = {carrier_sense, sync_quality, preamble_quality};
  assign term_en  = {cs_timeout_mask, sync_quality_timeout_mask,
                     preamble_quality_timeout_mask};
  assign any_en   = term_en != 3'h0;
  assign or_hit   = (term_val & term_en) != 3'h0;
  // Masked-off terms count as true so AND ignores them
  assign and_hit  = &(term_val | ~term_en);

  // No mask bit set means the timeout is never stopped
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rx_timeout_stop <= 1'b0;
    end else begin
      rx_timeout_stop <= any_en & (timeout_combine_sel ? or_hit : and_hit);
    end
  end

  // ----------------------------------------
  // Timers, sync word, back-off seed
  // ----------------------------------------
  // Periods follow their registers one cycle late
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rx_timeout_period <= '0;
      wake_period       <= '0;
      alt_sync_word     <= 32'h0000_0000;
    end else begin
      rx_timeout_period.count    <= cfg_reg[11];
      rx_timeout_period.prescale <= cfg_reg[12];
      wake_period.prescale       <= cfg_reg[13];
      wake_period.count          <= cfg_reg[14];
      // Zero outside dual sync so stale bytes never match
      alt_sync_word <= dual_sync_en ? {own_node, allcall, group, sender_id}
                                    : 32'h0000_0000;
    end
  end

  // Reload pulse carries its own value, so no race with a write
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      wake_load       <= 1'b0;
      wake_load_value <= '0;
    end else begin
      wake_load <= sync_detect & wake_reload_on_sync;
      if (sync_detect && wake_reload_on_sync) begin
        wake_load_value.prescale <= cfg_reg[15];
        wake_load_value.count    <= cfg_reg[16];
      end
    end
  end

  // Seed is a level; the load strobe follows backoff_start one cycle late
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      backoff_seed      <= 15'h0000;
      backoff_seed_load <= 1'b0;
    end else begin
      backoff_seed      <= {cfg_reg[17][6:0], cfg_reg[18]};
      backoff_seed_load <= backoff_start & seed_reload_en;
    end
  end

endmodule

// [hdl/pktcfg_params.svh]
// Offsets, reset values, field positions and masks of the
// packet protocol configuration register slice.
// Assumes an 8-bit register address space on the serial port.
`ifndef PKTCFG_PARAMS_SVH
`define PKTCFG_PARAMS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define ACK_AND_RECEIVE_CONTROL_OFS 8'h3B
`define RX_FIFO_FULL_LEVEL_OFS      8'h3C
`define RX_FIFO_EMPTY_LEVEL_OFS     8'h3D
`define TX_FIFO_FULL_LEVEL_OFS      8'h3E
`define TX_FIFO_EMPTY_LEVEL_OFS     8'h3F
`define PACKET_FILTER_OPTIONS_OFS   8'h40
`define SOURCE_MATCH_MASK_OFS       8'h41
`define OWN_NODE_OR_SYNC3_OFS       8'h42
`define ALLCALL_OR_SYNC2_OFS        8'h43
`define GROUP_OR_SYNC1_OFS          8'h44
`define SENDER_ID_OR_SYNC0_OFS      8'h45
`define RX_TIMEOUT_COUNT_OFS        8'h46
`define RX_TIMEOUT_PRESCALE_OFS     8'h47
`define WAKEUP_PRESCALE_OFS         8'h48
`define WAKEUP_COUNT_OFS            8'h49
`define WAKEUP_RELOAD_PRESCALE_OFS  8'h4A
`define WAKEUP_RELOAD_COUNT_OFS     8'h4B
`define BACKOFF_SEED_HIGH_OFS       8'h4C
`define BACKOFF_SEED_LOW_OFS        8'h4D
`define REG_COUNT                   19

// ----------------------------------------
// Reset values and writable masks
// ----------------------------------------
`define ACK_CTRL_RST     8'h08
`define FIFO_LEVEL_RST   8'h30
`define FILTER_OPT_RST   8'h40
`define ZERO_RST         8'h00
`define ONE_RST          8'h01
`define SEED_HIGH_RST    8'h4C
`define ACK_CTRL_MASK    8'hFE
`define SEVEN_BIT_MASK   8'h7F
`define FILTER_OPT_MASK  8'h5F
`define FULL_MASK        8'hFF

// ----------------------------------------
// Field positions
// ----------------------------------------
`define SUPPRESS_ACK_BIT  3
`define AUTO_ACK_BIT      2
`define PERSIST_RX_BIT    1
`define TIMEOUT_SEL_BIT   6
`define SRC_MATCH_BIT     4
`define ALLCALL_BIT       3
`define GROUP_BIT         2
`define OWN_NODE_BIT      1
`define BAD_CHECK_BIT     0
`define READ_FLAG_BIT     0

`endif

// [hdl/pktcfg_pkg.sv]
// Types shared by the packet protocol configuration slice.
// Assumes nothing of its surroundings.
package pktcfg_pkg;

  // Received packet header as seen by the filter
  typedef struct packed {
    logic [7:0] dest;
    logic [7:0] src;
    logic       crc_ok;
    logic       ack_req;
  } rx_packet_s;

  // Fields inserted into a transmitted packet
  typedef struct packed {
    logic [7:0] dest;
    logic [7:0] src;
    logic       no_ack;
  } tx_header_s;

  // Prescaler and counter pair of a timer
  typedef struct packed {
    logic [7:0] prescale;
    logic [7:0] count;
  } timer_period_s;

  // FIFO level flags
  typedef struct packed {
    logic rx_full;
    logic rx_empty;
    logic tx_full;
    logic tx_empty;
  } fifo_flags_s;

endpackage

// [hdl/spi_reg_port.sv]
// Serial register port: mode 0, header byte, address byte,
// then data bytes with auto-increment of the address.
// Assumes the system clock runs at least 8x the serial clock.
`timescale 1ns/1ns
`include "pktcfg_params.svh"
module spi_reg_port (
  input  wire logic       clock,
  input  wire logic       rstn,
  input  wire logic       sclk,
  input  wire logic       csn,
  input  wire logic       mosi,
  input  wire logic [7:0] rd_data,
  output logic [7:0]      addr,
  output logic [7:0]      wr_data,
  output logic            wr_en,
  output logic            miso,
  output logic            miso_oe
);
  logic [1:0] sclk_pipe_reg, csn_pipe_reg, mosi_pipe_reg;
  logic       sclk_prev_reg, is_read_reg, load_reg, inc_reg;
  logic [2:0] bit_cnt_reg;
  logic [1:0] byte_cnt_reg;
  logic [6:0] shift_in_reg;
  logic [7:0] shift_out_reg;
  logic       rise, fall, active, done;
  logic [7:0] in_byte;

  // Two-stage synchronisers on every pin
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      sclk_pipe_reg <= 2'h0;
      csn_pipe_reg  <= 2'h3;
      mosi_pipe_reg <= 2'h0;
      sclk_prev_reg <= 1'b0;
    end else begin
      sclk_pipe_reg <= {sclk_pipe_reg[0], sclk};
      csn_pipe_reg  <= {csn_pipe_reg[0], csn};
      mosi_pipe_reg <= {mosi_pipe_reg[0], mosi};
      sclk_prev_reg <= sclk_pipe_reg[1];
    end
  end

  assign active  = ~csn_pipe_reg[1];
  assign rise    = active & sclk_pipe_reg[1] & ~sclk_prev_reg;
  assign fall    = active & ~sclk_pipe_reg[1] & sclk_prev_reg;
  assign done    = rise & (bit_cnt_reg == 3'h7);
  assign in_byte = {shift_in_reg, mosi_pipe_reg[1]};

  // Frame decode; counters restart whenever select drops
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      bit_cnt_reg <= 3'h0;
      byte_cnt_reg <= 2'h0;
      shift_in_reg <= 7'h00;
      is_read_reg <= 1'b0;
      addr <= 8'h00;
      wr_data <= 8'h00;
      wr_en <= 1'b0;
      load_reg <= 1'b0;
      inc_reg <= 1'b0;
    end else begin
      wr_en <= 1'b0;
      load_reg <= 1'b0;
      inc_reg <= 1'b0;
      if (inc_reg) begin
        addr <= addr + 8'h01;
        load_reg <= is_read_reg;
      end
      if (!active) begin
        bit_cnt_reg <= 3'h0;
        byte_cnt_reg <= 2'h0;
      end else if (rise) begin
        shift_in_reg <= in_byte[6:0];
        bit_cnt_reg <= bit_cnt_reg + 3'h1;
      end
      if (done) begin
        case (byte_cnt_reg)
          2'h0: is_read_reg <= in_byte[`READ_FLAG_BIT];
          2'h1: begin
            addr <= in_byte;
            load_reg <= is_read_reg;
          end
          default: begin
            wr_en <= ~is_read_reg;
            wr_data <= in_byte;
            inc_reg <= 1'b1;
          end
        endcase
        if (byte_cnt_reg != 2'h2) begin
          byte_cnt_reg <= byte_cnt_reg + 2'h1;
        end
      end
    end
  end

  // Read data out; first bit set up before the first rising edge
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      shift_out_reg <= 8'h00;
      miso <= 1'b0;
      miso_oe <= 1'b0;
    end else begin
      miso_oe <= active;
      if (load_reg) begin
        miso <= rd_data[7];
        shift_out_reg <= {rd_data[6:0], 1'b0};
      end else if (fall && bit_cnt_reg != 3'h0) begin
        miso <= shift_out_reg[7];
        shift_out_reg <= {shift_out_reg[6:0], 1'b0};
      end
    end
  end
endmodule

// [hdl/packet_filter.sv]
// Combinational receive packet acceptance decision.
// Assumes its inputs are stable registers of the same clock.
`timescale 1ns/1ns
`include "pktcfg_params.svh"
module packet_filter (
  input  wire logic                   auto_filter_en,
  input  wire logic                   dual_sync_en,
  input  wire logic [7:0]             options,
  input  wire logic [7:0]             src_mask,
  input  wire logic [7:0]             own_node,
  input  wire logic [7:0]             allcall,
  input  wire logic [7:0]             group,
  input  wire logic [7:0]             sender_id,
  input  wire pktcfg_pkg::rx_packet_s pkt,
  output logic                        accept
);
  logic [3:0] enables, hits;
  logic       addr_ok, crc_ok;

  // Address bytes double as sync bytes, so no address test then
  assign enables = dual_sync_en ? 4'h0 : {options[`SRC_MATCH_BIT], options[`ALLCALL_BIT],
                                          options[`GROUP_BIT], options[`OWN_NODE_BIT]};
  assign hits[3] = (pkt.src & src_mask) == (own_node & src_mask);
  assign hits[2] = pkt.dest == allcall;
  assign hits[1] = pkt.dest == group;
  assign hits[0] = pkt.dest == own_node || pkt.dest == sender_id;

  // Any enabled match passes; no filter enabled passes all
  assign addr_ok = (enables == 4'h0) || ((enables & hits) != 4'h0);
  assign crc_ok  = ~options[`BAD_CHECK_BIT] | pkt.crc_ok;
  assign accept  = ~auto_filter_en | (addr_ok & crc_ok);
endmodule

// [tb/spi_host_model.sv]
// Host side of the serial register port: mode 0, MSB first.
// Assumes the bench calls xfer just after a rising clock edge.
`timescale 1ns/1ns
module spi_host_model (
  input  wire logic clock,
  output logic      sclk,
  output logic      csn,
  output logic      mosi,
  input  wire logic miso
);
  // Idle pins at time zero
  initial begin
    sclk = 1'b0;
    csn  = 1'b1;
    mosi = 1'b0;
  end

  // One byte; eight clocks per half period, a 16x ratio, twice the port's 8x minimum
  task automatic shift(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      mosi <= tx[i];
      repeat (8) @(posedge clock);
      sclk <= 1'b1;
      rx[i] = miso;
      repeat (8) @(posedge clock);
      sclk <= 1'b0;
    end
  endtask

  // Header, address and one data byte; released mosi shows its inverse
  task automatic xfer(input logic rd, input logic [7:0] a, d, output logic [7:0] q);
    logic [7:0] x;
    csn <= 1'b0;
    repeat (4) @(posedge clock);
    shift({7'h00, rd}, x);
    shift(a, x);
    shift(d, q);
    repeat (8) @(posedge clock);
    csn  <= 1'b1;
    mosi <= ~mosi;
    repeat (16) @(posedge clock);
  endtask
endmodule

// [tb/packet_protocol_config_regs_monitor.sv]
// Concurrent checks on the configuration slice ports.
// Assumes one clock domain and an active-low asynchronous reset.
`timescale 1ns/1ns
module packet_protocol_config_regs_monitor (
  input wire logic        clock,
  input wire logic        rstn,
  input wire logic        auto_filter_en,
  input wire logic        dual_sync_en,
  input wire logic        wake_reload_on_sync,
  input wire logic        seed_reload_en,
  input wire logic        rx_pkt_valid,
  input wire logic        sync_detect,
  input wire logic        backoff_start,
  input wire logic        spi_csn,
  input wire logic        spi_miso_oe,
  input wire logic        rx_accept,
  input wire logic        rx_discard,
  input wire logic        ack_send,
  input wire logic [31:0] alt_sync_word,
  input wire logic        wake_load,
  input wire logic        backoff_seed_load
);
  // ----------------------------------------
  // Packet, event and read driver enable checks
  // ----------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  // Reload request as the engine raises it
  sequence reload_req;
    sync_detect && wake_reload_on_sync;
  endsequence

  a_pkt_one_result: assert property (rx_pkt_valid |=> rx_accept != rx_discard)
    else $error("packet without a single verdict");
  a_result_cause: assert property ((rx_accept || rx_discard) |-> $past(rx_pkt_valid))
    else $error("verdict without a packet");
  a_filter_off: assert property (rx_pkt_valid && !auto_filter_en |=> rx_accept)
    else $error("packet refused with filtering off");
  a_ack_with_accept: assert property (ack_send |-> rx_accept)
    else $error("ack sent for a refused packet");
  a_alt_sync_off: assert property (!dual_sync_en |=> alt_sync_word == 32'h00000000)
    else $error("alternate sync word shown outside dual mode");
  a_wake_reload: assert property (reload_req |=> wake_load)
    else $error("wake reload missed");
  a_wake_cause: assert property (wake_load |-> $past(sync_detect && wake_reload_on_sync))
    else $error("wake reload without request");
  a_seed_reload: assert property (backoff_start && seed_reload_en |=> backoff_seed_load)
    else $error("seed reload missed");
  a_oe_follows_sel: assert property ($stable(spi_csn) [*4] |-> spi_miso_oe == !spi_csn)
    else $error("read driver enable not following select");
endmodule

bind packet_protocol_config_regs packet_protocol_config_regs_monitor i_mon (.*);

// [tb/test_packet_protocol_config_regs.sv]
// Self-checking bench of the packet protocol configuration registers.
// Assumes the host model and the bound monitor are compiled with it.
`timescale 1ns/1ns
module test_packet_protocol_config_regs;
  logic                      clock, rstn, spi_sclk, spi_csn, spi_mosi, spi_miso, spi_miso_oe;
  logic                      auto_filter_en, dual_sync_en, wake_reload_on_sync, seed_reload_en;
  logic                      cs_timeout_mask, sync_quality_timeout_mask, preamble_quality_timeout_mask;
  logic                      carrier_sense, sync_quality, preamble_quality, rx_pkt_valid, sync_detect;
  logic                      backoff_start, persistent_receive, rx_timeout_stop, rx_accept, rx_discard;
  logic                      ack_send, wake_load, backoff_seed_load, ack_on;
  logic [7:0]                rx_fill, tx_fill, q;
  logic [14:0]               backoff_seed;
  logic [31:0]               alt_sync_word;
  pktcfg_pkg::rx_packet_s    rx_pkt;
  pktcfg_pkg::fifo_flags_s   fifo_flags;
  pktcfg_pkg::tx_header_s    tx_header;
  pktcfg_pkg::timer_period_s rx_timeout_period, wake_period, wake_load_value;
  int                        err_total, compares;
  // Reset values and readable masks from 3B to 4D
  localparam logic [7:0] rst_v [19] = '{8'h08, 8'h30, 8'h30, 8'h30, 8'h30, 8'h40, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h01, 8'h00, 8'h01, 8'h00, 8'h01, 8'h00, 8'h4C, 8'h00};
  localparam logic [7:0] msk [19] = '{8'hFE, 8'h7F, 8'h7F, 8'h7F, 8'h7F, 8'h5F, 8'hFF, 8'hFF, 8'hFF,
    8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h7F, 8'hFF};
  // Packets: options, dest, src, crc_ok nibble, accept nibble
  localparam logic [31:0] pk [14] = '{32'h02420011, 32'h02450011, 32'h02110010, 32'h04440011,
    32'h04430010, 32'h08430011, 32'h08440010, 32'h10004011, 32'h10004110, 32'h01000000,
    32'h01000011, 32'h0C440011, 32'h0D440000, 32'h00110001};
  // Fill levels: rx, tx, flags {rx_full, rx_empty, tx_full, tx_empty}
  localparam logic [31:0] ff [4] = '{32'h3C3E000F, 32'h3B3D0005, 32'h3E40000A, 32'h80000009};

  spi_host_model i_spi_host_model (
    .clock (clock),
    .sclk  (spi_sclk),
    .csn   (spi_csn),
    .mosi  (spi_mosi),
    .miso  (spi_miso)
  );
  packet_protocol_config_regs i_packet_protocol_config_regs (.*);

  // 250 MHz clock
  always #2 clock = ~clock;

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, d);
    i_spi_host_model.xfer(1'b0, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, e);
    i_spi_host_model.xfer(1'b1, a, 8'h00, q);
    chk(q, e);
  endtask
  // Options written first, so each packet sees its own filter setup
  task automatic pkt(input logic [31:0] c);
    wr(8'h40, c[31:24]);
    rx_pkt <= '{dest: c[23:16], src: c[15:8], crc_ok: c[4], ack_req: 1'b1};
    rx_pkt_valid <= 1'b1;
    @(posedge clock);
    rx_pkt_valid <= 1'b0;
    #1 chk({rx_accept, rx_discard, ack_send}, {c[0], ~c[0], c[0] & ack_on});
    @(posedge clock);
  endtask
  task automatic report_and_stop;
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    clock = 1'b0;
    rstn = 1'b0;
    {auto_filter_en, dual_sync_en, wake_reload_on_sync, seed_reload_en, cs_timeout_mask} = '0;
    {sync_quality_timeout_mask, preamble_quality_timeout_mask, carrier_sense, sync_quality} = '0;
    {preamble_quality, rx_pkt_valid, sync_detect, backoff_start, rx_fill, tx_fill, rx_pkt} = '0;
    {err_total, compares, ack_on} = '0;
    repeat (2) @(posedge clock);
    rstn <= 1'b1;
    repeat (2) @(posedge clock);
    chk({tx_header, backoff_seed}, {8'h00, 8'h00, 1'b1, 15'h4C00});
    chk({rx_timeout_period, wake_period}, 32'h00010100);
    for (int i = 0; i < 19; i++) rd(8'(8'h3B + i), rst_v[i]);
    for (int i = 0; i < 19; i++) begin
      wr(8'(8'h3B + i), 8'hFF);
      rd(8'(8'h3B + i), msk[i]);
      wr(8'(8'h3B + i), 8'(8'h3B + i));
      rd(8'(8'h3B + i), 8'(8'h3B + i) & msk[i]);
    end
    wr(8'h50, 8'hFF);
    rd(8'h50, 8'h00);
    chk({tx_header, persistent_receive}, {8'h42, 8'h45, 1'b1, 1'b1});
    chk({rx_timeout_period, wake_period}, 32'h47464849);
    chk(backoff_seed, 15'h4C4D);
    foreach (ff[i]) begin
      rx_fill <= ff[i][31:24];
      tx_fill <= ff[i][23:16];
      repeat (3) @(posedge clock);
      chk(fifo_flags, ff[i][3:0]);
    end
    auto_filter_en <= 1'b1;
    foreach (pk[i]) pkt(pk[i]);
    dual_sync_en <= 1'b1;
    pkt(32'h02110011);
    chk(alt_sync_word, 32'h42434445);
    dual_sync_en <= 1'b0;
    auto_filter_en <= 1'b0;
    pkt(32'h01000001);
    wr(8'h3B, 8'h06);
    ack_on = 1'b1;
    pkt(32'h00110011);
    chk({tx_header.no_ack, persistent_receive}, 2'b01);
    // Timeout stop: OR with one term, then AND with all three
    cs_timeout_mask <= 1'b1;
    carrier_sense <= 1'b1;
    wr(8'h40, 8'h40);
    chk(rx_timeout_stop, 1'b1);
    sync_quality_timeout_mask <= 1'b1;
    preamble_quality_timeout_mask <= 1'b1;
    wr(8'h40, 8'h00);
    chk(rx_timeout_stop, 1'b0);
    sync_quality <= 1'b1;
    preamble_quality <= 1'b1;
    repeat (3) @(posedge clock);
    chk(rx_timeout_stop, 1'b1);
    // Reload events, both in the same cycle
    wake_reload_on_sync <= 1'b1;
    seed_reload_en <= 1'b1;
    sync_detect <= 1'b1;
    backoff_start <= 1'b1;
    @(posedge clock);
    sync_detect <= 1'b0;
    backoff_start <= 1'b0;
    #1 chk({wake_load, backoff_seed_load, wake_load_value}, {2'b11, 16'h4A4B});
    report_and_stop();
  end

  // Watchdog well beyond the expected run of about 50000 cycles
  initial begin
    repeat (90000) @(posedge clock);
    err_total++;
    report_and_stop();
  end
endmodule
